// ### rtl/nand_host_pkg.sv
// Constants, types and timing for the two-die NAND host sequencer
package nand_host_pkg;
    // Clock period and least bus timings
    localparam int CLK_NS = 25;
    localparam int T_WP_NS = 40; // Write strobe low time
    localparam int T_WH_NS = 30; // Write strobe high time
    localparam int T_REA_NS = 20; // Read strobe to data valid
    localparam int T_WHR_NS = 80; // Command to status read turnaround
    localparam int T_WB_NS = 100; // Write strobe to busy assertion
    localparam int SYNC_STAGES = 2;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RE_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1;
    localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    // Command codes
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_STAT_DIE0 = 8'hf1;
    localparam logic [7:0] CMD_STAT_DIE1 = 8'hf2;
    localparam logic [7:0] CMD_STAT_ALL = 8'h70; // Never sent by this host
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_P2 = 8'h81;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_PROG_P1 = 8'h11;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    // Status byte layout
    localparam int STATUS_READY_BIT = 6;
    // Sequence store
    localparam int SEQ_MAX = 14;
    localparam int ADDR_BYTES = 5;
    localparam int ROW_BYTES = 3;
    // Host operations
    typedef enum logic [1:0] {OP_RESET, OP_PROGRAM, OP_ERASE} op_t;
    // One bus cycle in a sequence
    typedef struct packed {
        logic is_addr; // Address latch instead of command latch
        logic [7:0] val; // Byte placed on the bus
    } seq_ent_t;
    typedef seq_ent_t [SEQ_MAX-1:0] seq_arr_t;
    // Pins driven toward the flash
    typedef struct packed {
        logic ce_n; // Chip enable
        logic cle; // Command latch enable
        logic ale; // Address latch enable
        logic we_n; // Write strobe
        logic re_n; // Read strobe
        logic wp_n; // Write protect, held inactive
        logic io_oe; // Bus drive enable
        logic [7:0] io_out; // Bus data out
    } pin_out_t;
    localparam pin_out_t PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
        wp_n: 1'b1, io_oe: 1'b0, io_out: 8'h00};
endpackage : nand_host_pkg

// ### rtl/nand_host_ctrl.sv
// Host sequencer for reset, interleaved program/erase and per-die status polling
// Summary of operation
// [R1] Reset is command byte FFh
// [R2] Reset aborts the device's busy operation
// [R3] Aborted program/erase leaves cells invalid
// [R4] Reset clears command register; status C0h
// [R5] Reset accepted even during reset; this host takes no request until its own reset sequence returns to S_IDLE
// [R6] Ready/busy low for reset time, then released
// [R7] Power-up latches read setup; reset idles
// [R8] Second die programs while first is busy
// [R9] F1h polls first die status only
// [R10] F2h polls second die status only
// [R11] No new program to a busy die
// [R12] Status bit six: one ready, zero busy
// [R13] Never use 70h during interleaving
// [R14] Erase interleaves between dies likewise
// [R15] Two-plane program/erase interleave too
// [R16] Ready/busy high when idle
// [R17] Ready/busy low after program/erase/read start
// [R18] Ready/busy rises when operation finishes
// [R19] Ready/busy is open-drain, wire-OR
// [R20] Status low nibble is don't-care
`timescale 1ns/1ps
module nand_host_ctrl (
    input wire logic i_clock, // 40 MHz clock
    input wire logic i_arst_n, // Asynchronous reset, active low
    input wire logic i_req_valid, // Operation request
    output logic o_req_ready, // Request can be taken this cycle
    input wire nand_host_pkg::op_t i_req_op, // Reset, program or erase
    input wire logic i_req_die, // Target die
    input wire logic i_req_two_plane, // Two-plane variant
    input wire logic [39:0] i_req_addr, // First plane address, low byte first
    input wire logic [39:0] i_req_addr2, // Second plane address
    output logic [1:0] o_die_busy, // Die has an operation in flight
    output logic o_status_valid, // Pulse: status byte captured
    output logic o_status_die, // Die that the status belongs to
    output logic [7:0] o_status, // Captured status byte
    output nand_host_pkg::pin_out_t o_pins, // Flash control and bus out
    input wire logic [7:0] i_io_in, // Flash bus in
    input wire logic i_rb // Wire-OR ready/busy line
);
    import nand_host_pkg::*;

    typedef enum {S_IDLE, S_SEND, S_WB, S_RB, S_WHR, S_READ} state_t;

    state_t st_q, st_d; // Sequencer state
    seq_arr_t seq_q, seq_d; // Bytes of the current sequence
    logic [3:0] len_q, len_d; // Sequence length
    logic [3:0] idx_q, idx_d; // Byte being sent
    logic [3:0] ph_q, ph_d; // Phase inside one bus cycle
    logic is_reset_q, is_reset_d; // Current sequence is a reset
    logic is_poll_q, is_poll_d; // Current sequence is a status poll
    logic die_q, die_d; // Die that the sequence targets
    logic [1:0] busy_q, busy_d; // Per-die busy tracking
    logic stv_q, stv_d; // Status pulse
    logic [7:0] stat_q, stat_d; // Status byte
    pin_out_t pins_q, pins_d; // Registered pins
    logic [7:0] io_s1_q, io_s2_q; // Bus synchroniser
    logic rb_s1_q, rb_s2_q; // Ready/busy synchroniser
    logic accept; // Request taken
    logic poll_die; // Die picked for the next poll

    // Build the byte list of a program or erase, with one or two planes
    function automatic seq_arr_t build_seq(input op_t op, input logic two, input logic [39:0] a1,
                                           input logic [39:0] a2, output logic [3:0] n);
        seq_arr_t s;
        int k;
        s = '0;
        k = 0;
        if (op == OP_PROGRAM) begin
            s[k] = '{1'b0, CMD_PROG}; k++;
            for (int i = 0; i < ADDR_BYTES; i++) begin s[k] = '{1'b1, a1[8*i +: 8]}; k++; end
            if (two) begin // First plane ends with the plane confirm
                s[k] = '{1'b0, CMD_PROG_P1}; k++; // R15
                s[k] = '{1'b0, CMD_PROG_P2}; k++;
                for (int i = 0; i < ADDR_BYTES; i++) begin s[k] = '{1'b1, a2[8*i +: 8]}; k++; end
            end
            s[k] = '{1'b0, CMD_PROG_GO}; k++;
        end else begin
            s[k] = '{1'b0, CMD_ERASE}; k++;
            for (int i = 0; i < ROW_BYTES; i++) begin s[k] = '{1'b1, a1[16+8*i +: 8]}; k++; end
            if (two) begin // Second block address follows a repeated erase setup
                s[k] = '{1'b0, CMD_ERASE}; k++; // R15
                for (int i = 0; i < ROW_BYTES; i++) begin s[k] = '{1'b1, a2[16+8*i +: 8]}; k++; end
            end
            s[k] = '{1'b0, CMD_ERASE_GO}; k++;
        end
        n = 4'(k);
        return s;
    endfunction : build_seq

    // Reset may be taken whatever the dies do; other work only for a ready die
    assign accept = i_req_valid && o_req_ready;
    assign o_req_ready = (st_q == S_IDLE) && ((i_req_op == OP_RESET) || !busy_q[i_req_die]); // R5 R8 R11 R14
    // Alternate polls so that neither die starves
    assign poll_die = busy_q[~die_q] ? ~die_q : die_q;

    // Next-state logic of the whole sequencer
    always_comb begin
        logic [3:0] n;
        n = '0;
        st_d = st_q;
        seq_d = seq_q;
        len_d = len_q;
        idx_d = idx_q;
        ph_d = ph_q;
        is_reset_d = is_reset_q;
        is_poll_d = is_poll_q;
        die_d = die_q;
        busy_d = busy_q;
        stv_d = 1'b0;
        stat_d = stat_q;
        pins_d = PINS_IDLE;
        unique case (st_q)
            S_IDLE: begin
                idx_d = '0;
                ph_d = '0;
                if (accept) begin // User work wins over background polling
                    st_d = S_SEND;
                    die_d = i_req_die;
                    is_poll_d = 1'b0;
                    is_reset_d = (i_req_op == OP_RESET);
                    if (i_req_op == OP_RESET) begin
                        seq_d = '0;
                        seq_d[0] = '{1'b0, CMD_RESET}; // R1
                        len_d = 4'h1;
                    end else begin
                        seq_d = build_seq(i_req_op, i_req_two_plane, i_req_addr, i_req_addr2, n); // R14 R15
                        len_d = n;
                    end
                end else if (|busy_q) begin // Only the die-specific status is ever asked
                    st_d = S_SEND;
                    die_d = poll_die;
                    is_poll_d = 1'b1;
                    is_reset_d = 1'b0;
                    seq_d = '0;
                    seq_d[0] = '{1'b0, poll_die ? CMD_STAT_DIE1 : CMD_STAT_DIE0}; // R9 R10 R13
                    len_d = 4'h1;
                end
            end
            S_SEND: begin
                pins_d.ce_n = 1'b0;
                pins_d.cle = !seq_q[idx_q].is_addr;
                pins_d.ale = seq_q[idx_q].is_addr;
                pins_d.io_oe = 1'b1;
                pins_d.io_out = seq_q[idx_q].val;
                pins_d.we_n = (ph_q >= 4'(WP_CYC)); // Data latched on the rising strobe
                ph_d = ph_q + 4'h1;
                if (ph_q == 4'(WP_CYC + WH_CYC - 1)) begin
                    ph_d = '0;
                    idx_d = idx_q + 4'h1;
                    if (idx_q == len_q - 4'h1) begin
                        if (is_poll_q) begin
                            st_d = S_WHR;
                        end else if (is_reset_q) begin
                            st_d = S_WB;
                        end else begin // Die left to run on its own; polled later
                            busy_d[die_q] = 1'b1; // R8 R11
                            st_d = S_IDLE;
                        end
                    end
                end
            end
            S_WB: begin // Busy line needs time to fall after the reset strobe
                pins_d.ce_n = 1'b0;
                ph_d = ph_q + 4'h1;
                if (ph_q == 4'(WB_CYC - 1)) begin
                    ph_d = '0;
                    st_d = S_RB;
                end
            end
            S_RB: begin // Wire-OR line high means every die finished its reset
                pins_d.ce_n = 1'b0;
                if (rb_s2_q) begin
                    busy_d = 2'b00; // R2 R3 R6
                    st_d = S_IDLE;
                end
            end
            S_WHR: begin
                pins_d.ce_n = 1'b0;
                ph_d = ph_q + 4'h1;
                if (ph_q == 4'(WHR_CYC - 1)) begin
                    ph_d = '0;
                    st_d = S_READ;
                end
            end
            S_READ: begin // Strobe held long enough to cover pin delay and the synchroniser
                pins_d.ce_n = 1'b0;
                pins_d.re_n = (ph_q == 4'(RE_CYC));
                ph_d = ph_q + 4'h1;
                if (ph_q == 4'(RE_CYC)) begin
                    stv_d = 1'b1;
                    stat_d = io_s2_q;
                    if (io_s2_q[STATUS_READY_BIT]) begin // Low nibble ignored
                        busy_d[die_q] = 1'b0; // R12 R20
                    end
                    st_d = S_IDLE;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= S_IDLE;
            seq_q <= '0;
            len_q <= '0;
            idx_q <= '0;
            ph_q <= '0;
            is_reset_q <= 1'b0;
            is_poll_q <= 1'b0;
            die_q <= 1'b0;
            busy_q <= 2'b00;
            stv_q <= 1'b0;
            stat_q <= 8'h00;
            pins_q <= PINS_IDLE;
        end else begin
            st_q <= st_d;
            seq_q <= seq_d;
            len_q <= len_d;
            idx_q <= idx_d;
            ph_q <= ph_d;
            is_reset_q <= is_reset_d;
            is_poll_q <= is_poll_d;
            die_q <= die_d;
            busy_q <= busy_d;
            stv_q <= stv_d;
            stat_q <= stat_d;
            pins_q <= pins_d;
        end
    end

    // Two-stage synchronisers on pin inputs; line idles high under its pull-up
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
        end else begin
            io_s1_q <= i_io_in;
            io_s2_q <= io_s1_q;
            rb_s1_q <= i_rb; // R19
            rb_s2_q <= rb_s1_q;
        end
    end

    assign o_pins = pins_q;
    assign o_die_busy = busy_q;
    assign o_status_valid = stv_q;
    assign o_status_die = die_q;
    assign o_status = stat_q;

    // Checks on the pin sequences
    sequence cmd_byte(logic [7:0] c);
        pins_q.cle && pins_q.io_oe && (pins_q.io_out == c);
    endsequence

    a_no_general_status: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R13
        not cmd_byte(CMD_STAT_ALL)) else $error("general status command driven");
    a_reset_code_out: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R1
        accept && (i_req_op == OP_RESET) |-> ##2 cmd_byte(CMD_RESET) ##1 (!pins_q.we_n))
        else $error("reset request did not send FFh");
    a_poll_die_one: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R9
        cmd_byte(CMD_STAT_DIE0) |-> is_poll_q && !die_q && busy_q[0]) else $error("F1h not for first die");
    a_poll_die_two: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R10
        cmd_byte(CMD_STAT_DIE1) |-> is_poll_q && die_q && busy_q[1]) else $error("F2h not for second die");
    // Judged per flag: a moving die index alone must not look like a new busy die
    a_busy_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R11
        (busy_q & ~$past(busy_q)) != 2'b00 |-> $past(st_q) == S_SEND && !$past(is_poll_q)
            && ((busy_q & ~$past(busy_q)) == (2'b01 << $past(die_q))))
        else $error("busy set off a send");
    a_ready_clears: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R12
        stv_q && stat_q[STATUS_READY_BIT] |-> !busy_q[die_q]) else $error("ready status left die busy");
    a_busy_holds: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R12
        stv_q && !stat_q[STATUS_READY_BIT] |-> busy_q[die_q]) else $error("busy status freed die");
    a_interleave_ok: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R8
        (st_q == S_IDLE) && busy_q[0] && !busy_q[1] && i_req_valid && i_req_die |-> o_req_ready)
        else $error("ready die blocked by busy die");
    a_erase_confirm: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R14
        accept && (i_req_op == OP_ERASE) && !i_req_two_plane |-> ##1 (len_q == 4'(ROW_BYTES + 2)))
        else $error("erase sequence length wrong");
endmodule : nand_host_ctrl

// ### bench/nand_dev_model.sv
// Behavioural two-die flash on the shared bus
`timescale 1ns/1ps
module nand_dev_model #(
    parameter int PROG_NS = 8000, // Program/erase busy time
    parameter int RST_NS = 1500 // Reset busy time
) (
    input wire logic i_ce_n, // Chip enable, low
    input wire logic i_cle, // Command latch
    input wire logic i_ale, // Address latch
    input wire logic i_we_n, // Write strobe, low
    input wire logic i_re_n, // Read strobe, low
    input wire logic [7:0] i_io, // Bus from host
    output logic [7:0] o_io, // Bus toward host
    output logic o_io_oe, // Model drives bus
    output logic o_rb_pull, // Open-drain pull-down
    output int o_faults // Host violations seen
);
    int busy_ns[2] = '{0, 0}; // Busy time left per die
    int rst_ns = 0; // Reset time left
    int ops[2] = '{0, 0}; // Operations started per die
    int addr_cnt = 0; // Address bytes since last command
    logic [7:0] last_addr = 8'h00; // Bit 7 picks the die
    logic [3:0] lo_q[2] = '{4'h0, 4'h0}; // Undefined low nibble
    logic sel_q = 1'b0; // Die of last status command
    logic stat_mode = 1'b0; // Power-up acts as read setup latched
    logic [7:0] stat_q = 8'h00; // Frozen for the whole read
    initial o_faults = 0;
    // Internal timers; a real part has no clock pin
    always #5 begin
        for (int d = 0; d < 2; d++) if (busy_ns[d] > 0) busy_ns[d] -= 5;
        if (rst_ns > 0) rst_ns -= 5;
    end
    assign o_rb_pull = (rst_ns > 0) || (busy_ns[0] > 0) || (busy_ns[1] > 0);
    assign o_io_oe = !i_ce_n && !i_re_n && stat_mode;
    // Released bus shows the inverse so no stale byte passes
    assign o_io = o_io_oe ? stat_q : ~stat_q;
    always @(negedge i_re_n) begin
        stat_q = {(rst_ns == 0 && busy_ns[sel_q] == 0) ? 4'hc : 4'h8, lo_q[sel_q]};
    end
    // Bytes latch on the rising write strobe
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_ale) begin
            last_addr = i_io;
            addr_cnt++;
        end
        if (!i_ce_n && i_cle) begin
            stat_mode = 1'b0;
            case (i_io)
                8'hff: begin
                    busy_ns = '{0, 0};
                    lo_q = '{4'h0, 4'h0};
                    rst_ns = RST_NS;
                end
                8'hf1, 8'hf2: begin
                    sel_q = i_io[1];
                    stat_mode = 1'b1;
                end
                8'h10, 8'h11, 8'hd0: begin
                    if (addr_cnt != ((i_io == 8'hd0) ? 3 : 5)) o_faults++;
                    if (busy_ns[last_addr[7]] > 0 || rst_ns > 0) o_faults++;
                    if (i_io != 8'h11) begin
                        busy_ns[last_addr[7]] = PROG_NS;
                        ops[last_addr[7]]++;
                        lo_q[last_addr[7]] = 4'h5;
                    end
                end
                8'h70: o_faults++;
                default: ;
            endcase
            addr_cnt = 0;
        end
    end
endmodule : nand_dev_model

// ### bench/nand_host_ctrl_tb.sv
// Bench: reset abort, interleaved program/erase, per-die polls
`timescale 1ns/1ps
module nand_host_ctrl_tb;
    import nand_host_pkg::*;
    logic clock = 1'b0; // 40 MHz
    logic arst_n = 1'b0; // Reset, active low
    logic req_valid = 1'b0;
    op_t req_op = OP_RESET;
    logic req_die = 1'b0;
    logic req_two_plane = 1'b0;
    logic ext_pull = 1'b0; // Another part on the ready/busy wire
    logic req_ready, status_valid, status_die, dev_oe, dev_pull, rb;
    logic [1:0] die_busy;
    logic [7:0] status, io_in, dev_io;
    pin_out_t pins;
    int dev_faults;
    int fail_count = 0;
    int tests_run = 0;
    int pend = 0; // Cycles until the busy flag is rechecked
    logic pend_die = 1'b0;
    always #12.5 clock = ~clock;
    assign rb = ~(dev_pull | ext_pull);
    assign io_in = dev_oe ? dev_io : (pins.io_oe ? pins.io_out : dev_io);
    nand_host_ctrl uut (.i_clock(clock), .i_arst_n(arst_n), .i_req_valid(req_valid), .o_req_ready(req_ready),
        .i_req_op(req_op), .i_req_die(req_die), .i_req_two_plane(req_two_plane),
        .i_req_addr({req_die, 39'h00_1234_5678}), .i_req_addr2({req_die, 39'h00_0004_0000}),
        .o_die_busy(die_busy), .o_status_valid(status_valid), .o_status_die(status_die), .o_status(status),
        .o_pins(pins), .i_io_in(io_in), .i_rb(rb));
    nand_dev_model dev (.i_ce_n(pins.ce_n), .i_cle(pins.cle), .i_ale(pins.ale), .i_we_n(pins.we_n),
        .i_re_n(pins.re_n), .i_io(pins.io_out), .o_io(dev_io), .o_io_oe(dev_oe), .o_rb_pull(dev_pull),
        .o_faults(dev_faults));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // Step one cycle; a used-up bound ends the run
    task automatic step(inout int n, input int lim);
        @(negedge clock);
        n++;
        if (n > lim) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : step
    task automatic send(input op_t op, input logic die, input logic tp);
        int n;
        n = 0;
        @(negedge clock);
        req_op = op;
        req_die = die;
        req_two_plane = tp;
        req_valid = 1'b1;
        // Ready is judged at the rising edge, where the design takes the request
        @(posedge clock);
        while (req_ready !== 1'b1) begin
            step(n, 3000);
            @(posedge clock);
        end
        @(negedge clock);
        req_valid = 1'b0;
    endtask : send
    task automatic wait_idle();
        int n;
        n = 0;
        while (!(req_ready === 1'b1 && die_busy === 2'b00)) step(n, 6000);
    endtask : wait_idle
    // Every captured status matches the polled die's byte
    always @(negedge clock) begin
        if (pend == 1) chk({15'h0, die_busy[pend_die]}, 16'h0);
        if (pend > 0) pend--;
        if (status_valid === 1'b1) begin
            chk({8'h00, status}, {8'h00, dev.stat_q});
            chk({15'h0, status_die}, {15'h0, dev.sel_q});
            pend = status[6] ? 2 : 0;
            pend_die = status_die;
        end
    end
    task automatic t_idle();
        chk({1'b0, pins}, {1'b0, PINS_IDLE});
        chk({14'h0, rb, req_ready}, 16'h3);
    endtask : t_idle
    // Reset over a running program, wire held low by a neighbour
    task automatic t_reset_abort();
        int n;
        n = 0;
        send(OP_PROGRAM, 1'b0, 1'b0);
        repeat (40) @(negedge clock);
        chk({14'h0, rb, die_busy[0]}, 16'h1);
        send(OP_RESET, 1'b0, 1'b0);
        ext_pull = 1'b1;
        while (dev_pull !== 1'b0) step(n, 120);
        repeat (20) @(negedge clock);
        chk({15'h0, req_ready}, 16'h0);
        ext_pull = 1'b0;
        repeat (2) @(negedge clock);
        wait_idle();
        chk({14'h0, die_busy}, 16'h0);
    endtask : t_reset_abort
    // Both dies busy together; a busy die refuses more work
    task automatic t_interleave(input op_t op, input logic tp);
        int o0, o1;
        o0 = dev.ops[0];
        o1 = dev.ops[1];
        send(op, 1'b0, tp);
        send(op, 1'b1, tp);
        repeat (70) @(negedge clock);
        chk({14'h0, die_busy}, 16'h3);
        req_die = 1'b0;
        req_valid = 1'b1;
        repeat (3) begin
            @(posedge clock);
            chk({15'h0, req_ready}, 16'h0);
        end
        @(negedge clock);
        req_valid = 1'b0;
        wait_idle();
        chk(16'(dev.ops[0] - o0), 16'h1);
        chk(16'(dev.ops[1] - o1), 16'h1);
    endtask : t_interleave
    initial begin
        repeat (8) @(negedge clock);
        arst_n = 1'b1;
        t_idle();
        t_reset_abort();
        t_interleave(OP_PROGRAM, 1'b0);
        t_interleave(OP_PROGRAM, 1'b1);
        t_interleave(OP_ERASE, 1'b0);
        t_interleave(OP_ERASE, 1'b1);
        chk(dev_faults[15:0], 16'h0);
        tally_and_finish();
    end
endmodule : nand_host_ctrl_tb
